//--- verilog/sev_status.sv
`timescale 1ns/1ps
// Function
// - reading an event register returns its pattern, then clears all its bits except those rising in that cycle.
// - a read answers as one decimal number, weight two to the bit position.
// - bit 0 of reading events sets on an over-range reading.
// - bit 1 of reading events sets when reading is below the lower bound.
// - bit 2 of reading events sets when reading is above the upper bound.
// - bit 5 of reading events sets when a reading is taken and processed.
// - bit 7 of reading events sets when the buffer holds two readings.
// - bit 8 of reading events sets when the buffer is half filled.
// - bit 9 of reading events sets when the buffer is filled.
// - unused bits of the reading register never set.
// - bit 4 of integrity events sets on an invalid reference junction.
// - invalid calibration constant at power-up sets bit 8; default constant used.
// - the calibration fault clears only after a successful calibration.
// - bit 14 of integrity events sets when a command parameter is ignored.
// - the fault lamp is lit while any integrity event stands.
// - bit 4 of activity events sets while measuring.
// - bit 5 of activity events sets in the trigger device-action stage.
// - bit 10 of activity events sets while idle.
// - each event is gated by its enable bit before reaching the summary.
// - each set has a live, unlatched condition register.
// - preset clears the three enable masks and nothing else.
module sev_status (
  // clock and reset
  input  logic               core_clk,
  input  logic               rst,
  // instrument status sources
  input  sev_pkg::sev_src_t  src,
  // host query port
  input  logic               req_valid,
  input  sev_pkg::sev_req_t  req,
  output logic               req_ready,
  // decimal answer
  output logic               ans_valid,
  output logic [19:0]        ans_bcd,
  // summaries and indicators
  output logic [2:0]         summary,
  output logic               fault_lamp,
  output logic               use_default_cal
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [15:0]         cond_vec    [sev_pkg::SETS];
  logic [15:0]         event_vec   [sev_pkg::SETS];
  logic [15:0]         live_vec    [sev_pkg::SETS];
  logic [15:0]         enable_vec  [sev_pkg::SETS];
  logic [2:0]          rd_clr;
  logic [2:0]          wr_en;
  logic                preset;
  logic                take;
  logic                set_ok;
  logic                is_read;
  logic                conv_start;
  logic [15:0]         read_mux;
  logic                cal_fault;
  logic                next_cal_fault;
  logic                next_fault_lamp;
  logic                next_req_ready;
  logic [15:0]         next_integrity;
  sev_pkg::sev_state_t state;
  sev_pkg::sev_state_t next_state;

  // ------------------------------------------------------------
  // live conditions
  // ------------------------------------------------------------

  // reading set: limit and buffer events from the measuring path
  always_comb begin
    cond_vec[0]                        = 16'h0000;
    cond_vec[0][sev_pkg::RD_OVER_BIT]  = src.over_range_reading;
    cond_vec[0][sev_pkg::RD_LOW_BIT]   = src.below_lower_bound;
    cond_vec[0][sev_pkg::RD_HIGH_BIT]  = src.above_upper_bound;
    cond_vec[0][sev_pkg::RD_READY_BIT] = src.new_reading_ready;
    cond_vec[0][sev_pkg::RD_TWO_BIT]   = src.buffer_has_two_readings;
    cond_vec[0][sev_pkg::RD_HALF_BIT]  = src.buffer_half_filled;
    cond_vec[0][sev_pkg::RD_FULL_BIT]  = src.buffer_filled;
  end

  // integrity set: the calibration bit follows the held fault, not the pulse
  always_comb begin
    cond_vec[1]                       = 16'h0000;
    cond_vec[1][sev_pkg::IN_TEMP_BIT] = src.ref_junction_invalid;
    cond_vec[1][sev_pkg::IN_CAL_BIT]  = cal_fault;
    cond_vec[1][sev_pkg::IN_WARN_BIT] = src.cmd_param_ignored;
  end

  // activity set: trigger model stages
  always_comb begin
    cond_vec[2]                       = 16'h0000;
    cond_vec[2][sev_pkg::AC_MEAS_BIT] = src.measuring;
    cond_vec[2][sev_pkg::AC_TRIG_BIT] = src.trig_action;
    cond_vec[2][sev_pkg::AC_IDLE_BIT] = src.idle;
  end

  // ------------------------------------------------------------
  // calibration fault
  // ------------------------------------------------------------

  // a fresh bad-constant report wins over a calibration finishing together
  always_comb begin
    if (src.cal_constant_invalid) begin
      next_cal_fault = 1'b1;
    end else if (src.cal_success) begin
      next_cal_fault = 1'b0;
    end else begin
      next_cal_fault = cal_fault;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cal_fault <= 1'b0;
    end else begin
      cal_fault <= next_cal_fault;
    end
  end

  assign use_default_cal = cal_fault;

  // ------------------------------------------------------------
  // register sets
  // ------------------------------------------------------------

  // one bank per set; unused bits are masked inside the bank
  for (genvar g = 0; g < sev_pkg::SETS; g++) begin : g_set
    sev_bank #(
      .MASK (sev_pkg::set_mask(g))
    ) u_bank (
      .core_clk    (core_clk),
      .rst         (rst),
      .cond_in     (cond_vec[g]),
      .rd_clr      (rd_clr[g]),
      .wr_en       (wr_en[g]),
      .wr_data     (req.data),
      .preset      (preset),
      .event_flags (event_vec[g]),
      .cond_flags  (live_vec[g]),
      .enable_mask (enable_vec[g]),
      .summary     (summary[g])
    );
  end

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------

  // commands are refused while a decimal answer is being built
  always_comb begin
    take       = req_valid && req_ready;
    set_ok     = int'(req.set) < sev_pkg::SETS;
    is_read    = req.cmd == sev_pkg::SEV_RD_EVENT || req.cmd == sev_pkg::SEV_RD_COND ||
                 req.cmd == sev_pkg::SEV_RD_ENABLE;
    conv_start = take && is_read;
    preset     = take && req.cmd == sev_pkg::SEV_PRESET;
    rd_clr     = 3'h0;
    wr_en      = 3'h0;
    read_mux   = 16'h0000;
    if (take && set_ok) begin
      if (req.cmd == sev_pkg::SEV_RD_EVENT) begin
        rd_clr[req.set] = 1'b1;
        read_mux        = event_vec[req.set];
      end else if (req.cmd == sev_pkg::SEV_RD_COND) begin
        read_mux = live_vec[req.set];
      end else if (req.cmd == sev_pkg::SEV_RD_ENABLE) begin
        read_mux = enable_vec[req.set];
      end else if (req.cmd == sev_pkg::SEV_WR_ENABLE) begin
        wr_en[req.set] = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // answer sequencing
  // ------------------------------------------------------------

  // reads hold the port until the decimal conversion is out
  always_comb begin
    next_state = state;
    case (state)
      sev_pkg::SEV_IDLE: begin
        if (conv_start) begin
          next_state = sev_pkg::SEV_BUSY;
        end
      end
      sev_pkg::SEV_BUSY: begin
        if (ans_valid) begin
          next_state = sev_pkg::SEV_IDLE;
        end
      end
      default: begin
        next_state = sev_pkg::SEV_IDLE;
      end
    endcase
    next_req_ready = next_state == sev_pkg::SEV_IDLE;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state     <= sev_pkg::SEV_IDLE;
      req_ready <= 1'b1;
    end else begin
      state     <= next_state;
      req_ready <= next_req_ready;
    end
  end

  // decimal weighting of the chosen register
  sev_dec u_dec (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (conv_start),
    .bin      (read_mux),
    .done     (ans_valid),
    .bcd_out  (ans_bcd)
  );

  // ------------------------------------------------------------
  // fault lamp
  // ------------------------------------------------------------

  // lamp tracks the integrity events, so it goes dark on the clearing read
  always_comb begin
    next_integrity  = rd_clr[1] ? sev_pkg::EVENT_RST : event_vec[1];
    next_integrity  = next_integrity | (cond_vec[1] & sev_pkg::INTEGRITY_MASK & ~live_vec[1]);
    next_fault_lamp = |next_integrity;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_lamp <= 1'b0;
    end else begin
      fault_lamp <= next_fault_lamp;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  int unsigned ans_num;

  assign ans_num = ans_bcd[19:16] * 10000 + ans_bcd[15:12] * 1000 +
                   ans_bcd[11:8] * 100 + ans_bcd[7:4] * 10 + ans_bcd[3:0];

  sequence s_read_taken;
    req_valid && req_ready && is_read;
  endsequence

  sequence s_answer_out;
    !ans_valid [*8] ##1 !ans_valid [*8] ##1 ans_valid;
  endsequence

  a_answer_time: assert property (s_read_taken |=> s_answer_out)
    else $error("answer not seventeen cycles after read");
  a_answer_value: assert property (ans_valid |-> ans_num == 32'($past(read_mux, 17)))
    else $error("decimal answer does not match register");
  a_busy_refuse: assert property (s_read_taken |=> !req_ready [*8])
    else $error("port accepted a request while busy");
  a_over_range: assert property ($rose(src.over_range_reading) |=> event_vec[0][0])
    else $error("over-range event not latched");
  a_buffer_full: assert property ($rose(src.buffer_filled) |=> event_vec[0][9])
    else $error("buffer-filled event not latched");
  a_idle_event: assert property ($rose(src.idle) |=> event_vec[2][10])
    else $error("idle event not latched");
  a_warn_event: assert property ($rose(src.cmd_param_ignored) |=> event_vec[1][14])
    else $error("ignored-parameter event not latched");
  a_cal_default: assert property (src.cal_constant_invalid && !use_default_cal |=>
    use_default_cal ##1 event_vec[1][8]) else $error("calibration fault not raised");
  a_cal_release: assert property ($fell(use_default_cal) |-> $past(src.cal_success))
    else $error("calibration fault cleared without calibration");
  a_lamp_follows: assert property (fault_lamp == |event_vec[1])
    else $error("fault lamp disagrees with integrity events");
  a_same_cycle: assert property (rd_clr[2] && $rose(src.measuring) |=>
    event_vec[2][4]) else $error("event lost against clearing read");

endmodule

//--- verilog/sev_pkg.sv
package sev_pkg;

  // ------------------------------------------------------------
  // widths and counts
  // ------------------------------------------------------------
  localparam int         REG_W      = 16;
  localparam int         SETS       = 3;
  localparam int         DIGITS     = 5;
  localparam int         BCD_W      = 20;
  localparam logic [4:0] CONV_STEPS = 5'h10;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] EVENT_RST  = 16'h0000;
  localparam logic [15:0] COND_RST   = 16'h0000;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [19:0] BCD_RST    = 20'h00000;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int RD_OVER_BIT  = 0;
  localparam int RD_LOW_BIT   = 1;
  localparam int RD_HIGH_BIT  = 2;
  localparam int RD_READY_BIT = 5;
  localparam int RD_TWO_BIT   = 7;
  localparam int RD_HALF_BIT  = 8;
  localparam int RD_FULL_BIT  = 9;
  localparam int IN_TEMP_BIT  = 4;
  localparam int IN_CAL_BIT   = 8;
  localparam int IN_WARN_BIT  = 14;
  localparam int AC_MEAS_BIT  = 4;
  localparam int AC_TRIG_BIT  = 5;
  localparam int AC_IDLE_BIT  = 10;

  // bits that may ever set, per register set
  localparam logic [15:0] READING_MASK   = 16'h03A7;
  localparam logic [15:0] INTEGRITY_MASK = 16'h4110;
  localparam logic [15:0] ACTIVITY_MASK  = 16'h0430;

  function automatic logic [15:0] set_mask(input int s);
    if (s == 0) return READING_MASK;
    else if (s == 1) return INTEGRITY_MASK;
    else return ACTIVITY_MASK;
  endfunction

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SEV_RD_EVENT, SEV_RD_COND, SEV_RD_ENABLE, SEV_WR_ENABLE, SEV_PRESET
  } sev_cmd_t;

  typedef enum logic [1:0] {SEV_READING, SEV_INTEGRITY, SEV_ACTIVITY} sev_set_t;

  typedef enum logic {SEV_IDLE, SEV_BUSY} sev_state_t;

  typedef struct packed {
    sev_cmd_t    cmd;
    sev_set_t    set;
    logic [15:0] data;
  } sev_req_t;

  typedef struct packed {
    logic over_range_reading;
    logic below_lower_bound;
    logic above_upper_bound;
    logic new_reading_ready;
    logic buffer_has_two_readings;
    logic buffer_half_filled;
    logic buffer_filled;
    logic ref_junction_invalid;
    logic cal_constant_invalid;
    logic cal_success;
    logic cmd_param_ignored;
    logic measuring;
    logic trig_action;
    logic idle;
  } sev_src_t;

endpackage

//--- verilog/sev_bank.sv
`timescale 1ns/1ps
module sev_bank #(
  parameter logic [15:0] MASK = 16'hFFFF
) (
  // clock and reset
  input  logic        core_clk,
  input  logic        rst,
  // live status and host actions
  input  logic [15:0] cond_in,
  input  logic        rd_clr,
  input  logic        wr_en,
  input  logic [15:0] wr_data,
  input  logic        preset,
  // register contents
  output logic [15:0] event_flags,
  output logic [15:0] cond_flags,
  output logic [15:0] enable_mask,
  output logic        summary
);

  logic [15:0] rise;
  logic [15:0] next_event_flags;
  logic [15:0] next_cond_flags;
  logic [15:0] next_enable_mask;
  logic        next_summary;

  // events latch on a rising condition; a new event beats the clearing read
  always_comb begin
    rise             = cond_in & MASK & ~cond_flags;
    next_event_flags = (rd_clr ? sev_pkg::EVENT_RST : event_flags) | rise;
    next_cond_flags  = cond_in & MASK;
    if (preset) begin
      next_enable_mask = sev_pkg::ENABLE_RST;
    end else if (wr_en) begin
      next_enable_mask = wr_data & MASK;
    end else begin
      next_enable_mask = enable_mask;
    end
    next_summary = |(next_event_flags & next_enable_mask);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      event_flags <= sev_pkg::EVENT_RST;
      cond_flags  <= sev_pkg::COND_RST;
      enable_mask <= sev_pkg::ENABLE_RST;
      summary     <= 1'b0;
    end else begin
      event_flags <= next_event_flags;
      cond_flags  <= next_cond_flags;
      enable_mask <= next_enable_mask;
      summary     <= next_summary;
    end
  end

  a_read_clears: assert property (@(posedge core_clk) disable iff (rst)
    rd_clr |=> event_flags == $past(rise)) else $error("read did not clear events");
  a_event_sticky: assert property (@(posedge core_clk) disable iff (rst)
    !rd_clr |=> (event_flags & $past(event_flags)) == $past(event_flags))
    else $error("event dropped without a read");
  a_unused_bits: assert property (@(posedge core_clk) disable iff (rst)
    (event_flags & ~MASK) == 16'h0000) else $error("unused event bit set");
  a_preset_clears: assert property (@(posedge core_clk) disable iff (rst)
    preset |=> enable_mask == 16'h0000 && event_flags == ($past(event_flags) & ~{16{$past(rd_clr)}}
    | $past(rise))) else $error("preset misbehaved");
  a_summary_gate: assert property (@(posedge core_clk) disable iff (rst)
    summary == |(event_flags & enable_mask)) else $error("summary not gated by mask");

endmodule

//--- verilog/sev_dec.sv
`timescale 1ns/1ps
module sev_dec (
  // clock and reset
  input  logic        core_clk,
  input  logic        rst,
  // binary in
  input  logic        start,
  input  logic [15:0] bin,
  // decimal out
  output logic        done,
  output logic [19:0] bcd_out
);

  logic [15:0] shreg;
  logic [19:0] acc;
  logic [19:0] adj;
  logic [4:0]  cnt;
  logic [15:0] next_shreg;
  logic [19:0] next_acc;
  logic [4:0]  next_cnt;
  logic        next_done;
  logic [19:0] next_bcd_out;

  // shift-and-add-three, one bit a cycle: slow but tiny
  always_comb begin
    adj = acc;
    for (int d = 0; d < sev_pkg::DIGITS; d++) begin
      if (acc[4*d +: 4] > 4'h4) begin
        adj[4*d +: 4] = acc[4*d +: 4] + 4'h3;
      end
    end
    next_shreg   = shreg;
    next_acc     = acc;
    next_cnt     = cnt;
    next_done    = 1'b0;
    next_bcd_out = bcd_out;
    if (start) begin
      next_shreg = bin;
      next_acc   = sev_pkg::BCD_RST;
      next_cnt   = sev_pkg::CONV_STEPS;
    end else if (cnt != 5'h00) begin
      next_shreg = {shreg[14:0], 1'b0};
      next_acc   = {adj[18:0], shreg[15]};
      next_cnt   = cnt - 5'h01;
      if (cnt == 5'h01) begin
        next_done    = 1'b1;
        next_bcd_out = {adj[18:0], shreg[15]};
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shreg   <= 16'h0000;
      acc     <= sev_pkg::BCD_RST;
      cnt     <= 5'h00;
      done    <= 1'b0;
      bcd_out <= sev_pkg::BCD_RST;
    end else begin
      shreg   <= next_shreg;
      acc     <= next_acc;
      cnt     <= next_cnt;
      done    <= next_done;
      bcd_out <= next_bcd_out;
    end
  end

endmodule

//--- tb/sev_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side of the query port
// ------------------------------------------------------------
module sev_host (
  // clock
  input  logic              core_clk,
  // answers from the device
  input  logic              req_ready,
  input  logic              ans_valid,
  input  logic [19:0]       ans_bcd,
  // requests toward the device
  output logic              req_valid,
  output sev_pkg::sev_req_t req
);
  // idle until the first request
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // call just after a rising edge; held until taken, then the fields are
  // scrambled so that nobody can lean on a stale request
  task automatic query(input sev_pkg::sev_cmd_t c, input sev_pkg::sev_set_t s,
                       input logic [15:0] d, output logic [19:0] bcd, output int lat);
    bcd = 20'hFFFFF;
    lat = 0;
    req_valid <= 1'b1;
    req       <= '{cmd: c, set: s, data: d};
    @(posedge core_clk);
    while (req_ready !== 1'b1) @(posedge core_clk);
    req_valid <= 1'b0;
    req       <= sev_pkg::sev_req_t'(~{c, s, d});
    if (c == sev_pkg::SEV_WR_ENABLE || c == sev_pkg::SEV_PRESET) return;
    repeat (40) begin
      @(posedge core_clk);
      #1;
      lat++;
      if (ans_valid === 1'b1) begin
        bcd = ans_bcd;
        lat++; // seen just after its launch edge; the device side samples it one edge on
        return;
      end
    end
  endtask
endmodule

//--- tb/sev_status_bench.sv
`timescale 1ns/1ps
module sev_status_bench;
  typedef struct {
    logic [13:0]       pat;
    sev_pkg::sev_set_t set;
    logic [15:0]       exp;
  } sev_row_t;

  logic              core_clk;
  logic              rst;
  sev_pkg::sev_src_t src;
  logic              req_valid;
  sev_pkg::sev_req_t req;
  logic              req_ready;
  logic              ans_valid;
  logic [19:0]       ans_bcd;
  logic [2:0]        summary;
  logic              fault_lamp;
  logic              use_default_cal;
  logic [19:0]       got_bcd;
  int                got_lat;
  int                failures;
  int                checks_done;
  sev_row_t          rows [13];

  // ------------------------------------------------------------
  // device and host
  // ------------------------------------------------------------
  sev_status dut_u (.core_clk(core_clk), .rst(rst), .src(src), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .ans_valid(ans_valid), .ans_bcd(ans_bcd),
    .summary(summary), .fault_lamp(fault_lamp), .use_default_cal(use_default_cal));
  sev_host host_u (.core_clk(core_clk), .req_ready(req_ready), .ans_valid(ans_valid),
    .ans_bcd(ans_bcd), .req_valid(req_valid), .req(req));

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // own decimal conversion, kept apart from the device's converter
  function automatic logic [19:0] to_bcd(input logic [15:0] v);
    int n;
    n = v;
    for (int i = 0; i < 5; i++) begin
      to_bcd[i*4 +: 4] = 4'(n % 10);
      n = n / 10;
    end
  endfunction

  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ask(input sev_pkg::sev_cmd_t c, input sev_pkg::sev_set_t s,
                     input logic [15:0] d);
    @(posedge core_clk);
    host_u.query(c, s, d, got_bcd, got_lat);
  endtask

  // one source pulse, then let the events settle
  task automatic pulse(input logic [13:0] p);
    @(posedge core_clk);
    src <= sev_pkg::sev_src_t'(p);
    repeat (2) @(posedge core_clk);
    src <= '0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    src = '0;
    failures = 0;
    checks_done = 0;
    rows = '{'{14'h2000, sev_pkg::SEV_READING, 16'h0001},
             '{14'h1000, sev_pkg::SEV_READING, 16'h0002},
             '{14'h0800, sev_pkg::SEV_READING, 16'h0004},
             '{14'h0400, sev_pkg::SEV_READING, 16'h0020},
             '{14'h0200, sev_pkg::SEV_READING, 16'h0080},
             '{14'h0100, sev_pkg::SEV_READING, 16'h0100},
             '{14'h0080, sev_pkg::SEV_READING, 16'h0200},
             '{14'h3F80, sev_pkg::SEV_READING, 16'h03A7},
             '{14'h0040, sev_pkg::SEV_INTEGRITY, 16'h0010},
             '{14'h0008, sev_pkg::SEV_INTEGRITY, 16'h4000},
             '{14'h0004, sev_pkg::SEV_ACTIVITY, 16'h0010},
             '{14'h0002, sev_pkg::SEV_ACTIVITY, 16'h0020},
             '{14'h0001, sev_pkg::SEV_ACTIVITY, 16'h0400}};
    @(posedge core_clk);
    #1;
    check("outputs in reset", 20'h00040,
          20'({req_ready, ans_valid, summary, fault_lamp, use_default_cal}));
    check("answer in reset", 20'h00000, ans_bcd);
    @(posedge core_clk);
    rst <= 1'b0;
    // each source sets its own bit, holds it after the source drops, read clears
    foreach (rows[i]) begin
      pulse(rows[i].pat);
      check("lamp before read", 20'(rows[i].set == sev_pkg::SEV_INTEGRITY), 20'(fault_lamp));
      ask(sev_pkg::SEV_RD_EVENT, rows[i].set, 16'h0000);
      check("event read", to_bcd(rows[i].exp), got_bcd);
      check("answer latency", 20'h00011, 20'(got_lat));
      ask(sev_pkg::SEV_RD_EVENT, rows[i].set, 16'h0000);
      check("event after clear", 20'h00000, got_bcd);
      check("lamp after read", 20'h00000, 20'(fault_lamp));
    end
    // masks gate the summaries; preset clears masks only
    ask(sev_pkg::SEV_WR_ENABLE, sev_pkg::SEV_READING, 16'h0220);
    ask(sev_pkg::SEV_WR_ENABLE, sev_pkg::SEV_INTEGRITY, 16'h0000);
    ask(sev_pkg::SEV_WR_ENABLE, sev_pkg::SEV_ACTIVITY, 16'hFFFF);
    ask(sev_pkg::SEV_RD_ENABLE, sev_pkg::SEV_ACTIVITY, 16'h0000);
    check("activity mask", to_bcd(16'h0430), got_bcd);
    ask(sev_pkg::SEV_RD_ENABLE, sev_pkg::SEV_READING, 16'h0000);
    check("reading mask", 20'h00544, got_bcd);
    pulse(14'h0440);
    check("summary masked", 20'h00001, 20'(summary));
    check("lamp while masked", 20'h00001, 20'(fault_lamp));
    ask(sev_pkg::SEV_PRESET, sev_pkg::SEV_READING, 16'h0000);
    @(posedge core_clk);
    #1;
    check("summary after preset", 20'h00000, 20'(summary));
    ask(sev_pkg::SEV_RD_ENABLE, sev_pkg::SEV_READING, 16'h0000);
    check("mask after preset", 20'h00000, got_bcd);
    ask(sev_pkg::SEV_RD_EVENT, sev_pkg::SEV_READING, 16'h0000);
    check("event kept by preset", 20'h00032, got_bcd);
    ask(sev_pkg::SEV_RD_EVENT, sev_pkg::SEV_INTEGRITY, 16'h0000);
    check("masked event kept", 20'h00016, got_bcd);
    // a rise on the very edge of a clearing read must survive it
    @(posedge core_clk);
    src <= sev_pkg::sev_src_t'(14'h0004);
    host_u.query(sev_pkg::SEV_RD_EVENT, sev_pkg::SEV_ACTIVITY, 16'h0000, got_bcd, got_lat);
    check("read during rise", 20'h00000, got_bcd);
    ask(sev_pkg::SEV_RD_COND, sev_pkg::SEV_ACTIVITY, 16'h0000);
    check("live condition", 20'h00016, got_bcd);
    ask(sev_pkg::SEV_RD_EVENT, sev_pkg::SEV_ACTIVITY, 16'h0000);
    check("event kept", 20'h00016, got_bcd);
    @(posedge core_clk);
    src <= '0;
    ask(sev_pkg::SEV_RD_COND, sev_pkg::SEV_ACTIVITY, 16'h0000);
    check("condition follows", 20'h00000, got_bcd);
    // calibration fault outlives the read until calibration succeeds
    pulse(14'h0020);
    check("default constant", 20'h00001, 20'(use_default_cal));
    ask(sev_pkg::SEV_RD_EVENT, sev_pkg::sev_set_t'(2'h3), 16'h0000);
    check("unmapped set", 20'h00000, got_bcd);
    ask(sev_pkg::SEV_RD_EVENT, sev_pkg::SEV_INTEGRITY, 16'h0000);
    check("cal event", 20'h00256, got_bcd);
    check("fault after read", 20'h00001, 20'(use_default_cal));
    pulse(14'h0010);
    check("fault after cal", 20'h00000, 20'(use_default_cal));
    final_report();
  end

  // watchdog, several times the expected run of about 800 cycles
  initial begin
    #500000;
    failures++;
    final_report();
  end
endmodule
